// *** cfb_regs.v ***
// cfb_regs.v: flag register, static base, stack pointers and the two
// banks of data/address/frame registers of the cpu core.
// assumes: one clock, synchronous reset, execution unit on same clock.
// Operation
// - 16-bit static base register for addressing
// - flag register: eleven flag bits in word
// - bit 0 captures alu carry or borrow
// - debug bit raises step irq, cleared on step ack
// - bit 2 set on zero result
// - bit 3 set on negative result
// - bit 4 selects register bank
// - bit 5 set on overflow
// - bit 6 gates maskable irq, ack clears
// - bit 7 selects user or interrupt stack
// - hw ack or swi 0-31 clears bit 7
// - bits 8-11 and 15 reserved
// - bits 12-14 hold priority level
// - accept irq only above current priority
// - two banks of data/address/frame registers
// - separate user and interrupt stack pointers
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "cfb_defines.vh"

module cfb_regs
(
    // clock and reset
    input  wire        i_clk,
    input  wire        i_sys_rst,
    // register port
    input  wire [3:0]  i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [15:0] o_rdata,
    // alu result flags
    input  wire        i_alu_upd,
    input  wire        i_alu_carry_en,
    input  wire        i_alu_carry,
    input  wire        i_alu_zero,
    input  wire        i_alu_sign,
    input  wire        i_alu_ovfl,
    // instruction boundary and software interrupt
    input  wire        i_instr_done,
    input  wire        i_swi_exec,
    input  wire [5:0]  i_swi_num,
    // maskable interrupt request and acknowledge
    input  wire        i_irq_req,
    input  wire [2:0]  i_irq_pri,
    input  wire        i_irq_ack,
    input  wire        i_step_ack,
    // banked register file access from execution unit
    input  wire [2:0]  i_bank_idx,
    input  wire        i_bank_wr,
    input  wire [15:0] i_bank_wdata,
    // stack pointer access from execution unit
    input  wire        i_sp_wr,
    input  wire [15:0] i_sp_wdata,
    // outputs to core
    output reg  [15:0] o_flags,
    output reg  [15:0] o_static_base,
    output reg  [15:0] o_stack_pointer,
    output reg  [15:0] o_bank_rdata,
    output reg         o_bank_sel,
    output reg         o_irq_accept,
    output reg         o_step_irq,
    output reg         o_irq
);

    // state
    reg  [15:0] flags;
    reg  [15:0] static_base_pointer;
    reg  [15:0] user_stack_pointer;
    reg  [15:0] interrupt_stack_pointer;
    reg  [15:0] bank_mem [0:13];
    reg  [2:0]  irq_stat;
    reg  [2:0]  irq_mask;
    reg  [15:0] next_flags;
    reg  [2:0]  next_stat;
    wire [2:0]  cur_pri;
    wire        accept;
    wire        hw_ack;
    wire        swi_low;
    wire        wr_bank_reg;

    // priority compare is strict; equal level stays pending
    assign cur_pri = flags[`CFB_FLG_PRI_HI:`CFB_FLG_PRI_LO];
    assign accept  = i_irq_req & flags[`CFB_FLG_IEN] & (i_irq_pri > cur_pri);
    assign hw_ack  = i_irq_ack | i_step_ack;
    assign swi_low = i_swi_exec & (i_swi_num < `CFB_SWI_LIMIT);
    assign wr_bank_reg = i_wr & i_addr[3];

    // bank memory index: bank select picks the upper seven words
    function [3:0] cfb_bidx;
        input       bank;
        input [2:0] idx;
        begin
            cfb_bidx = bank ? (4'h7 + {1'b0, idx}) : {1'b0, idx};
        end
    endfunction

    // flag next value: software write, then alu, then acknowledge clears
    always @*
    begin
        next_flags = flags;
        if (i_wr && i_addr == `CFB_OFF_FLAGS)
        begin
            next_flags = i_wdata & `CFB_FLG_MASK;
        end
        if (i_alu_upd)
        begin
            if (i_alu_carry_en)
            begin
                next_flags[`CFB_FLG_CARRY] = i_alu_carry;
            end
            next_flags[`CFB_FLG_ZERO] = i_alu_zero;
            next_flags[`CFB_FLG_SIGN] = i_alu_sign;
            next_flags[`CFB_FLG_OVFL] = i_alu_ovfl;
        end
        if (i_step_ack)
        begin
            next_flags[`CFB_FLG_DEBUG] = 1'b0;
        end
        if (hw_ack)
        begin
            next_flags[`CFB_FLG_IEN] = 1'b0;
        end
        if (hw_ack || swi_low)
        begin
            next_flags[`CFB_FLG_STKSEL] = 1'b0;
        end
    end

    // sticky status: a new event wins over a write-one clear
    always @*
    begin
        next_stat = irq_stat;
        if (i_wr && i_addr == `CFB_OFF_IRQ_STAT)
        begin
            next_stat = irq_stat & ~i_wdata[2:0];
        end
        if (i_step_ack)
        begin
            next_stat[`CFB_EV_STEP] = 1'b1;
        end
        if (i_irq_ack)
        begin
            next_stat[`CFB_EV_ACK] = 1'b1;
        end
        if (i_irq_req && !accept)
        begin
            next_stat[`CFB_EV_REJECT] = 1'b1;
        end
    end

    // architectural registers
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            flags                   <= `CFB_FLG_RST;
            static_base_pointer     <= `CFB_SB_RST;
            user_stack_pointer      <= `CFB_SP_RST;
            interrupt_stack_pointer <= `CFB_SP_RST;
            irq_stat                <= 3'h0;
            irq_mask                <= 3'h0;
        end
        else
        begin
            flags    <= next_flags;
            irq_stat <= next_stat;
            if (i_wr && i_addr == `CFB_OFF_SBASE)
            begin
                static_base_pointer <= i_wdata;
            end
            if (i_wr && i_addr == `CFB_OFF_IRQ_MASK)
            begin
                irq_mask <= i_wdata[2:0];
            end
            // core writes the active pointer; software may load either
            if (i_sp_wr && flags[`CFB_FLG_STKSEL])
            begin
                user_stack_pointer <= i_sp_wdata;
            end
            else if (i_wr && i_addr == `CFB_OFF_USP)
            begin
                user_stack_pointer <= i_wdata;
            end
            if (i_sp_wr && !flags[`CFB_FLG_STKSEL])
            begin
                interrupt_stack_pointer <= i_sp_wdata;
            end
            else if (i_wr && i_addr == `CFB_OFF_ISP)
            begin
                interrupt_stack_pointer <= i_wdata;
            end
        end
    end

    // banked registers: r0-r3, a0, a1, fb per bank; no reset, as on silicon
    always @(posedge i_clk)
    begin
        if (i_bank_wr && i_bank_idx != 3'h7)
        begin
            bank_mem[cfb_bidx(flags[`CFB_FLG_BANK], i_bank_idx)] <= i_bank_wdata;
        end
        else if (wr_bank_reg && i_addr[2:0] != 3'h7)
        begin
            bank_mem[cfb_bidx(flags[`CFB_FLG_BANK], i_addr[2:0])] <= i_wdata;
        end
    end

    // registered outputs; selects seen one cycle after the flag write,
    // so the next instruction already uses the new bank and pointer
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_rdata         <= 16'h0000;
            o_flags         <= 16'h0000;
            o_static_base   <= 16'h0000;
            o_stack_pointer <= 16'h0000;
            o_bank_rdata    <= 16'h0000;
            o_bank_sel      <= 1'b0;
            o_irq_accept    <= 1'b0;
            o_step_irq      <= 1'b0;
            o_irq           <= 1'b0;
        end
        else
        begin
            o_flags         <= next_flags;
            o_static_base   <= static_base_pointer;
            o_bank_sel      <= next_flags[`CFB_FLG_BANK];
            o_stack_pointer <= next_flags[`CFB_FLG_STKSEL] ?
                               user_stack_pointer : interrupt_stack_pointer;
            o_bank_rdata    <= (i_bank_idx == 3'h7) ? 16'h0000 :
                               bank_mem[cfb_bidx(flags[`CFB_FLG_BANK], i_bank_idx)];
            o_irq_accept    <= accept;
            o_step_irq      <= i_instr_done & flags[`CFB_FLG_DEBUG] & ~i_step_ack;
            o_irq           <= |(next_stat & irq_mask);
            o_rdata         <= 16'h0000;
            if (i_rd)
            begin
                case (i_addr)
                    `CFB_OFF_FLAGS:    o_rdata <= flags;
                    `CFB_OFF_SBASE:    o_rdata <= static_base_pointer;
                    `CFB_OFF_USP:      o_rdata <= user_stack_pointer;
                    `CFB_OFF_ISP:      o_rdata <= interrupt_stack_pointer;
                    `CFB_OFF_IRQ_STAT: o_rdata <= {13'h0000, irq_stat};
                    `CFB_OFF_IRQ_MASK: o_rdata <= {13'h0000, irq_mask};
                    default:
                    begin
                        if (i_addr[3] && i_addr[2:0] != 3'h7)
                        begin
                            o_rdata <= bank_mem[cfb_bidx(flags[`CFB_FLG_BANK], i_addr[2:0])];
                        end
                        else
                        begin
                            o_rdata <= 16'h0000;
                        end
                    end
                endcase
            end
        end
    end

endmodule // cfb_regs

// *** cfb_defines.vh ***
// cfb_defines.vh: constants for the cpu flag and base register block
// assumes: included by the design file; holds definitions only
`ifndef CFB_DEFINES_VH
`define CFB_DEFINES_VH

// register offsets on the plain register port
`define CFB_OFF_FLAGS     4'h0
`define CFB_OFF_SBASE     4'h1
`define CFB_OFF_USP       4'h2
`define CFB_OFF_ISP       4'h3
`define CFB_OFF_IRQ_STAT  4'h4
`define CFB_OFF_IRQ_MASK  4'h5
`define CFB_OFF_BANK_REG  4'h8

// flag bit positions
`define CFB_FLG_CARRY     0
`define CFB_FLG_DEBUG     1
`define CFB_FLG_ZERO      2
`define CFB_FLG_SIGN      3
`define CFB_FLG_BANK      4
`define CFB_FLG_OVFL      5
`define CFB_FLG_IEN       6
`define CFB_FLG_STKSEL    7
`define CFB_FLG_PRI_LO    12
`define CFB_FLG_PRI_HI    14

// writable mask: bits 8 to 11 and 15 reserved, read as zero
`define CFB_FLG_MASK      16'h70FF

// reset values
`define CFB_FLG_RST       16'h0000
`define CFB_SB_RST        16'h0000
`define CFB_SP_RST        16'h0000

// software interrupt numbers below this clear the stack select
`define CFB_SWI_LIMIT     6'h20

// interrupt status bits
`define CFB_EV_STEP       0
`define CFB_EV_ACK        1
`define CFB_EV_REJECT     2

`endif

// *** cfb_core_model.sv ***
// cfb_core_model.sv: alu and acknowledge side of the flag block
// assumes: bench calls the tasks; one pulse each, on the block clock
`timescale 1ns/10ps
module cfb_core_model
(
    // clock
    input  wire       i_clk,
    // result flags and acknowledges
    output reg        o_upd,
    output reg        o_cen,
    output reg  [3:0] o_czso,
    output reg        o_ack,
    output reg        o_step_ack
);
    initial {o_upd, o_cen, o_czso, o_ack, o_step_ack} = 8'h00;
    // results flip after the pulse so a stale value never looks valid
    task alu(input [4:0] v);
        begin
            @(posedge i_clk);
            o_upd <= 1'b1;
            {o_cen, o_czso} <= v;
            @(posedge i_clk);
            o_upd <= 1'b0;
            o_czso <= ~v[3:0];
        end
    endtask
    // step acknowledge when s is set, hardware acknowledge otherwise
    task ack(input s);
        begin
            @(posedge i_clk);
            o_step_ack <= s;
            o_ack <= ~s;
            @(posedge i_clk);
            {o_ack, o_step_ack} <= 2'b00;
        end
    endtask
endmodule // cfb_core_model

// *** cfb_regs_checker.sv ***
// cfb_regs_checker.sv: port assertions for the flag register block
// assumes: bound to cfb_regs; one clock, sync active-high reset
`timescale 1ns/10ps
module cfb_regs_checker
(
    // clock, reset and core inputs
    input wire        i_clk, i_sys_rst, i_alu_upd, i_alu_carry_en,
    input wire        i_alu_carry, i_alu_zero, i_alu_sign, i_alu_ovfl,
    input wire        i_instr_done, i_swi_exec, i_irq_req, i_irq_ack, i_step_ack,
    input wire [5:0]  i_swi_num,
    input wire [2:0]  i_irq_pri,
    // watched outputs
    input wire [15:0] o_flags,
    input wire        o_irq_accept, o_step_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // alu results land on the edge after the update pulse
    carry_cap_a: assert property (i_alu_upd && i_alu_carry_en |=>
        o_flags[0] == $past(i_alu_carry)) else $error("carry flag stale");
    zso_cap_a: assert property (i_alu_upd |=> {o_flags[5], o_flags[3:2]} ==
        $past({i_alu_ovfl, i_alu_sign, i_alu_zero})) else $error("result flags stale");
    resv_zero_a: assert property ((o_flags & 16'h8F00) == 16'h0000)
        else $error("reserved flag bit set");
    ack_clear_a: assert property (i_irq_ack || i_step_ack |=> o_flags[7:6] == 2'b00)
        else $error("ack left enable or stack select");
    step_clear_a: assert property (i_step_ack |=> !o_flags[1])
        else $error("step ack left debug set");
    step_irq_a: assert property (i_instr_done && o_flags[1] && !i_step_ack |=> o_step_irq)
        else $error("step interrupt missing");
    prio_gate_a: assert property (o_irq_accept == $past(i_irq_req && o_flags[6] &&
        i_irq_pri > o_flags[14:12])) else $error("accept wrong for priority");
    swi_clear_a: assert property (i_swi_exec && i_swi_num < 6'h20 |=> !o_flags[7])
        else $error("swi left stack select");
    cover property (o_irq_accept);
    cover property (o_step_irq);
    cover property (i_irq_ack && o_flags[7]);
endmodule // cfb_regs_checker
bind cfb_regs cfb_regs_checker chk (.*);

// *** tb.sv ***
// tb.sv: self-checking bench for the flag and base register block
// assumes: cfb_regs, its checker and the core model are compiled first
`timescale 1ns/10ps
module tb;
    reg         i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_instr_done = 0;
    reg         i_swi_exec = 0, i_irq_req = 0;
    reg  [3:0]  i_addr = 4'h0;
    reg  [15:0] i_wdata = 16'h0000;
    reg  [5:0]  i_swi_num = 6'h00;
    reg  [2:0]  i_irq_pri = 3'h0;
    // core write paths, driven by t_core
    reg  [2:0]  i_bank_idx = 3'h0;
    reg         i_bank_wr = 1'b0, i_sp_wr = 1'b0;
    reg  [15:0] i_bank_wdata = 16'h0000, i_sp_wdata = 16'h0000;
    wire        i_alu_upd, i_alu_carry_en, i_alu_carry, i_alu_zero, i_alu_sign, i_alu_ovfl;
    wire        i_irq_ack, i_step_ack, o_bank_sel, o_irq_accept, o_step_irq, o_irq;
    wire [15:0] o_rdata, o_flags, o_static_base, o_stack_pointer, o_bank_rdata;
    integer     n_fail = 0, samples_checked = 0, cyc = 0, n_step = 0;
    cfb_regs uut (.*);
    cfb_core_model pm (.i_clk(i_clk), .o_upd(i_alu_upd), .o_cen(i_alu_carry_en),
        .o_czso({i_alu_carry, i_alu_zero, i_alu_sign, i_alu_ovfl}),
        .o_ack(i_irq_ack), .o_step_ack(i_step_ack));
    always #2 i_clk = ~i_clk;
    // cycles of step interrupt seen, and a ceiling far above the ~125 the tests need
    always @(posedge i_clk)
    begin
        if (o_step_irq === 1'b1) n_step = n_step + 1;
        cyc = cyc + 1;
        if (cyc == 3000) begin n_fail = n_fail + 1; conclude; end
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                n_fail = n_fail + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge i_clk); i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
            @(posedge i_clk); i_wr <= 1'b0; #1;
        end
    endtask
    // read data stands only in the cycle after the strobe, so look there
    task rdchk(input [3:0] a, input [15:0] e);
        begin
            @(posedge i_clk); i_addr <= a; i_rd <= 1'b1;
            @(posedge i_clk); i_rd <= 1'b0; #1 chk(o_rdata, e);
        end
    endtask
    task irq(input r, input [2:0] p, input [15:0] e);
        begin
            @(posedge i_clk); i_irq_req <= r; i_irq_pri <= p;
            repeat (3) @(posedge i_clk); #1 chk(o_irq_accept, e);
        end
    endtask
    task pulse(input s, input [5:0] n);
        begin
            @(posedge i_clk); i_instr_done <= ~s; i_swi_exec <= s; i_swi_num <= n;
            @(posedge i_clk); i_instr_done <= 1'b0; i_swi_exec <= 1'b0;
            repeat (2) @(posedge i_clk); #1;
        end
    endtask
    task t_regs;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) rdchk(i[3:0], 16'h0000);
            wr(4'h0, 16'hFFFF); chk(o_bank_sel, 16'h0001);
            rdchk(4'h0, 16'h70FF);
            wr(4'h1, 16'hA5C3); rdchk(4'h1, 16'hA5C3);
            chk(o_static_base, 16'hA5C3);
            wr(4'h7, 16'hFFFF); rdchk(4'h7, 16'h0000);
            $display("t_regs done");
        end
    endtask
    task t_alu;
        begin
            wr(4'h0, 16'h0000); pm.alu(5'b11101);
            rdchk(4'h0, 16'h0025);
            pm.alu(5'b00010); rdchk(4'h0, 16'h0009);
            $display("t_alu done");
        end
    endtask
    task t_sp_bank;
        begin
            wr(4'h2, 16'h1234); wr(4'h3, 16'h5678);
            wr(4'h0, 16'h0080); chk(o_stack_pointer, 16'h1234);
            wr(4'h0, 16'h0000); chk(o_stack_pointer, 16'h5678);
            wr(4'h8, 16'h1111); wr(4'h0, 16'h0010); wr(4'h8, 16'h2222);
            rdchk(4'h8, 16'h2222); chk(o_bank_rdata, 16'h2222);
            wr(4'h0, 16'h0000); rdchk(4'h8, 16'h1111);
            $display("t_sp_bank done");
        end
    endtask
    task t_irq;
        begin
            wr(4'h5, 16'h0002); wr(4'h0, 16'h30C0);
            irq(1'b1, 3'h3, 16'h0000);
            irq(1'b1, 3'h4, 16'h0001);
            irq(1'b0, 3'h4, 16'h0000);
            pm.ack(1'b0); #1 chk(o_flags, 16'h3000);
            irq(1'b1, 3'h7, 16'h0000);
            irq(1'b0, 3'h7, 16'h0000); chk(o_irq, 16'h0001);
            wr(4'h4, 16'hFFFF); repeat (2) @(posedge i_clk); #1 chk(o_irq, 16'h0000);
            $display("t_irq done");
        end
    endtask
    task t_step;
        begin
            wr(4'h0, 16'h00C2); pulse(1'b0, 6'h00); chk(n_step[15:0], 16'h0001);
            pm.ack(1'b1); #1 chk(o_flags, 16'h0000);
            pulse(1'b0, 6'h00); chk(n_step[15:0], 16'h0001);
            wr(4'h0, 16'h0080); pulse(1'b1, 6'h1F); chk(o_flags, 16'h0000);
            wr(4'h0, 16'h0080); pulse(1'b1, 6'h20); chk(o_flags, 16'h0080);
            $display("t_step done");
        end
    endtask
    // core writes land in the active pointer and the current bank
    task t_core;
        begin
            wr(4'h0, 16'h0000);
            @(posedge i_clk);
            i_sp_wr <= 1'b1;
            i_sp_wdata <= 16'hBEEF;
            i_bank_wr <= 1'b1;
            i_bank_idx <= 3'h2;
            i_bank_wdata <= 16'hC0DE;
            @(posedge i_clk);
            i_sp_wr <= 1'b0;
            i_bank_wr <= 1'b0;
            rdchk(4'h3, 16'hBEEF);
            rdchk(4'hA, 16'hC0DE);
            chk(o_stack_pointer, 16'hBEEF);
            chk(o_bank_rdata, 16'hC0DE);
            $display("t_core done");
        end
    endtask
    task conclude;
        begin
            $display("mismatches %0d comparisons %0d", n_fail, samples_checked);
            if (n_fail == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_regs; t_alu; t_sp_bank; t_irq; t_step; t_core;
        conclude;
    end
endmodule // tb
